// file: common/iot_pkg.sv
// constants and register map of the ten-channel io_timer block
package iot_pkg;
    localparam int          IOT_NUM_CH    = 10;
    localparam int          IOT_DMA_CH    = 8;
    localparam int          IOT_CW        = 16;
    localparam int          IOT_AW        = 8;
    // per-channel window: channel index in addr[7:4], register in addr[3:0]
    localparam logic [3:0]  IOT_CT_OFF    = 4'h0;
    localparam logic [3:0]  IOT_RL1_OFF   = 4'h4;
    localparam logic [3:0]  IOT_RL0_OFF   = 4'h6;
    localparam logic [3:0]  IOT_CTL_OFF   = 4'h8;
    localparam logic [7:0]  IOT_PRO_OFF   = 8'hbc;
    localparam logic [7:0]  IOT_EN_OFF    = 8'hbe;
    // control register fields
    localparam int          IOT_MODE_LSB  = 0;
    localparam int          IOT_EXTEN_BIT = 3;
    localparam int          IOT_LVL_BIT   = 4;
    localparam logic [4:0]  IOT_CTL_RST   = 5'h00;
    localparam logic [15:0] IOT_CNT_RST   = 16'h0000;
    localparam logic [15:0] IOT_ALL_ONES  = 16'hffff;
    localparam logic [9:0]  IOT_EN_RST    = 10'h000;
    localparam logic [9:0]  IOT_PRO_RST   = 10'h000;
    // mode codes of the control register
    localparam logic [2:0]  IOT_M_SINGLE  = 3'h0;
    localparam logic [2:0]  IOT_M_DELAYED = 3'h1;
    localparam logic [2:0]  IOT_M_CONT    = 3'h2;
    localparam logic [2:0]  IOT_M_PWM     = 3'h3;
    localparam logic [2:0]  IOT_M_MCLR    = 3'h4;
    localparam logic [2:0]  IOT_M_MFREE   = 3'h5;
    localparam logic [2:0]  IOT_M_NOISE_A = 3'h6;
    localparam logic [2:0]  IOT_M_NOISE_B = 3'h7;
endpackage

// file: rtl/iot_timer.sv
// ten-channel io_timer: per-channel counter engine and register slave
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module iot_channel
    import iot_pkg::*;
#(
    parameter bit DMA_CAPABLE = 1'b0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        en,
    input  wire logic        start,
    input  wire logic        tick,
    input  wire logic        capture,
    input  wire logic        level_in,
    input  wire logic [2:0]  mode,
    input  wire logic        lvl_pol,
    input  wire logic        wr_ct,
    input  wire logic        wr_rl0,
    input  wire logic        wr_rl1,
    input  wire logic [15:0] wdata,
    output logic      [15:0] ct_o,
    output logic      [15:0] rl0_o,
    output logic      [15:0] rl1_o,
    output logic             ff_o,
    output logic             irq_o,
    output logic             dma_o,
    output logic             uf_stop
);
    logic [15:0] ct_r;
    logic [15:0] rl0_r;
    logic [15:0] rl1_r;
    logic [15:0] act0_r;
    logic [15:0] act1_r;
    logic [15:0] stage0_r;
    logic [15:0] stage1_r;
    logic [15:0] load_val_r;
    logic        load_pend_r;
    logic        upd_pend_r;
    logic        start_pend_r;
    logic        nz_reload_r;
    logic        phase_r;
    logic        ff_r;
    logic        irq_r;
    logic        dma_r;
    logic        is_meas;
    logic        is_noise;
    logic        is_pwm;
    logic        is_out;
    logic        lvl_ok;
    logic        count_ok;
    logic        uf;
    logic        cap_hit;
    logic [15:0] next_phase_val;

    // mode decode; delayed and continuous output are not built and never count
    assign is_meas  = (mode == IOT_M_MCLR) || (mode == IOT_M_MFREE);
    assign is_noise = (mode == IOT_M_NOISE_A) || (mode == IOT_M_NOISE_B);
    assign is_pwm   = (mode == IOT_M_PWM);
    assign is_out   = is_pwm || (mode == IOT_M_SINGLE);
    assign lvl_ok   = (level_in == lvl_pol);
    assign cap_hit  = capture && en && is_meas;

    // a decrement happens only on a tick, never in a reload cycle
    assign count_ok = en && !load_pend_r && (is_meas || (is_out && !start_pend_r) ||
                      (is_noise && lvl_ok && !nz_reload_r));
    assign uf       = tick && count_ok && (ct_r == 16'h0000);
    assign uf_stop  = uf && (is_noise || (mode == IOT_M_SINGLE));
    // value for the phase after this underflow; pending reload zero write applies now
    assign next_phase_val = phase_r ? (upd_pend_r ? stage0_r : act0_r) : act1_r;

    // counter: write, capture clear, second reload cycle, then ticking
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ct_r <= IOT_CNT_RST;
        end else if (wr_ct && !is_pwm) begin
            ct_r <= wdata;
        end else if (cap_hit && mode == IOT_M_MCLR) begin
            ct_r <= IOT_ALL_ONES;
        end else if (load_pend_r) begin
            ct_r <= load_val_r;
        end else if (tick && en) begin
            if (start_pend_r && is_out) begin
                ct_r <= act0_r;
            end else if (is_noise && lvl_ok && nz_reload_r) begin
                ct_r <= rl0_r;
            end else if (count_ok) begin
                ct_r <= ct_r - 16'h0001; // wraps to all ones
            end
        end
    end

    // pwm reload: show all ones for one cycle, then the next phase value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_r <= 1'b0;
            load_val_r  <= IOT_CNT_RST;
        end else begin
            load_pend_r <= uf && is_pwm;
            if (uf && is_pwm) begin
                load_val_r <= next_phase_val;
            end
        end
    end

    // start pending until the first tick; counting then begins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_pend_r <= 1'b0;
        end else if (start) begin
            start_pend_r <= is_out;
        end else if (tick || !en) begin
            start_pend_r <= 1'b0;
        end
    end

    // noise filter: reload on start and after every invalid level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nz_reload_r <= 1'b0;
        end else if (start || (en && is_noise && !lvl_ok)) begin
            nz_reload_r <= 1'b1;
        end else if (tick && en && is_noise && lvl_ok) begin
            nz_reload_r <= 1'b0;
        end
    end

    // phase: 0 while the reload zero value runs, 1 for reload one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= 1'b0;
        end else if (start) begin
            phase_r <= 1'b0;
        end else if (uf && is_pwm) begin
            phase_r <= !phase_r;
        end
    end

    // output flip-flop toggles on the first tick after start and at each output-mode underflow
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ff_r <= 1'b0;
        end else if ((tick && en && start_pend_r && is_out) || (uf && is_out)) begin
            ff_r <= !ff_r;
        end
    end

    // written registers; reload zero doubles as the measure register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rl0_r <= IOT_CNT_RST;
            rl1_r <= IOT_CNT_RST;
        end else begin
            if (cap_hit) begin
                rl0_r <= wr_ct ? wdata : ct_r;
            end else if (wr_rl0 && !is_meas) begin
                rl0_r <= wdata;
            end
            if (wr_rl1) begin
                rl1_r <= wdata;
            end
        end
    end

    // buffers in use; while pwm runs a reload zero write stages both values
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            act0_r     <= IOT_CNT_RST;
            act1_r     <= IOT_CNT_RST;
            stage0_r   <= IOT_CNT_RST;
            stage1_r   <= IOT_CNT_RST;
            upd_pend_r <= 1'b0;
        end else if (!(en && is_pwm)) begin
            if (wr_rl0 && !is_meas) begin
                act0_r <= wdata;
            end
            if (wr_rl1) begin
                act1_r <= wdata;
            end
            upd_pend_r <= 1'b0;
        end else begin
            // reload one written after reload zero is not staged
            if (wr_rl0) begin
                stage0_r   <= wdata;
                stage1_r   <= rl1_r;
                upd_pend_r <= 1'b1;
            end else if (uf && phase_r && upd_pend_r) begin
                act0_r     <= stage0_r;
                act1_r     <= stage1_r;
                upd_pend_r <= 1'b0;
            end
        end
    end

    // request pulses, one cycle after the event
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
            dma_r <= 1'b0;
        end else begin
            irq_r <= (is_meas && (uf || cap_hit)) || (is_pwm && uf && phase_r) ||
                     ((is_noise || mode == IOT_M_SINGLE) && uf);
            dma_r <= DMA_CAPABLE && uf;
        end
    end

    assign ct_o  = ct_r;
    assign rl0_o = rl0_r;
    assign rl1_o = rl1_r;
    assign ff_o  = ff_r;
    assign irq_o = irq_r;
    assign dma_o = dma_r;

    pwm_reload_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uf && is_pwm) |=> (ct_r == IOT_ALL_ONES) ##1 (ct_r == $past(load_val_r)))
        else $error("pwm reload did not show all ones then the reload value");
    pwm_odd_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uf && is_pwm && !phase_r) |=> !irq_r)
        else $error("interrupt raised on an odd pwm underflow");
    ff_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uf && is_out) |=> (ff_r != $past(ff_r)))
        else $error("output flip-flop did not toggle on underflow");
    meas_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cap_hit && !wr_ct) |=> (rl0_r == $past(ct_r)) && irq_r)
        else $error("capture did not latch the count");
    clr_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cap_hit && !wr_ct && mode == IOT_M_MCLR) |=> (ct_r == IOT_ALL_ONES))
        else $error("measure clear capture did not set all ones");
    cap_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cap_hit && wr_ct) |=> (ct_r == $past(wdata)) && (rl0_r == $past(wdata)))
        else $error("written value not loaded and latched together");
    pwm_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!en && is_pwm && !load_pend_r) [*2] |-> $stable(ct_r))
        else $error("pwm counter moved while disabled");
    meas_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uf && is_meas && !wr_ct && !cap_hit) |=> (ct_r == IOT_ALL_ONES) && irq_r)
        else $error("measure underflow did not wrap to all ones");
    pwm_even_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (uf && is_pwm && phase_r) ##1 irq_r);
    single_stop_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (uf && mode == IOT_M_SINGLE));
    noise_pause_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (en && is_noise && lvl_ok) ##1 !lvl_ok ##[1:20] (tick && lvl_ok && nz_reload_r));
endmodule

module iot_timer
    import iot_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [9:0]  count_tick,
    input  wire logic [9:0]  ext_enable,
    input  wire logic [9:0]  capture,
    input  wire logic [9:0]  level_in,
    output logic      [9:0]  timer_out,
    output logic      [9:0]  irq_req,
    output logic             dma_req
);
    logic [9:0]  channel_count_enable_r;
    logic [9:0]  channel_count_enable_nxt;
    logic [9:0]  enable_write_protect_r;
    logic [4:0]  ctl_r [IOT_NUM_CH];
    logic [15:0] ct_rd [IOT_NUM_CH];
    logic [15:0] rl0_rd [IOT_NUM_CH];
    logic [15:0] rl1_rd [IOT_NUM_CH];
    logic [9:0]  uf_stop;
    logic [9:0]  start;
    logic [9:0]  ext_en_g;
    logic [9:0]  dma_all;
    logic [9:0]  en_wbits;
    logic        en_wr;
    logic [3:0]  ch_sel;
    logic [3:0]  sub_sel;
    logic        ch_ok;
    logic [15:0] rdata_r;

    assign ch_sel   = reg_addr[7:4];
    assign sub_sel  = reg_addr[3:0];
    assign ch_ok    = (ch_sel < 4'(IOT_NUM_CH));
    assign en_wr    = reg_wr && (reg_addr == IOT_EN_OFF);
    assign en_wbits = reg_wdata[9:0];

    // enable bits: permitted software write first, then underflow stop, then external
    always_comb begin
        for (int i = 0; i < IOT_NUM_CH; i++) begin
            ext_en_g[i] = ext_enable[i] && ctl_r[i][IOT_EXTEN_BIT];
            if (en_wr && !enable_write_protect_r[i]) begin
                channel_count_enable_nxt[i] = en_wbits[i];
            end else if (uf_stop[i]) begin
                channel_count_enable_nxt[i] = 1'b0;
            end else if (ext_en_g[i]) begin
                channel_count_enable_nxt[i] = 1'b1;
            end else begin
                channel_count_enable_nxt[i] = channel_count_enable_r[i];
            end
            // a software enable over a same-clock stop restarts the shot
            start[i] = channel_count_enable_nxt[i] &&
                       (!channel_count_enable_r[i] || uf_stop[i]);
        end
    end

    // enable and protect registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            channel_count_enable_r <= IOT_EN_RST;
            enable_write_protect_r <= IOT_PRO_RST;
        end else begin
            channel_count_enable_r <= channel_count_enable_nxt;
            if (reg_wr && reg_addr == IOT_PRO_OFF) begin
                enable_write_protect_r <= en_wbits;
            end
        end
    end

    // control registers; mode changes only while the channel is stopped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < IOT_NUM_CH; i++) begin
                ctl_r[i] <= IOT_CTL_RST;
            end
        end else if (reg_wr && ch_ok && sub_sel == IOT_CTL_OFF &&
                     !channel_count_enable_r[ch_sel]) begin
            ctl_r[ch_sel] <= reg_wdata[4:0];
        end
    end

    // channel engines
    for (genvar g = 0; g < IOT_NUM_CH; g++) begin : g_ch
        iot_channel #(
            .DMA_CAPABLE (g == IOT_DMA_CH)
        ) u_ch (
            .clk_sys  (clk_sys),
            .rst_n    (rst_n),
            .en       (channel_count_enable_r[g]),
            .start    (start[g]),
            .tick     (count_tick[g]),
            .capture  (capture[g]),
            .level_in (level_in[g]),
            .mode     (ctl_r[g][IOT_MODE_LSB +: 3]),
            .lvl_pol  (ctl_r[g][IOT_LVL_BIT]),
            .wr_ct    (reg_wr && ch_sel == 4'(g) && sub_sel == IOT_CT_OFF),
            .wr_rl0   (reg_wr && ch_sel == 4'(g) && sub_sel == IOT_RL0_OFF),
            .wr_rl1   (reg_wr && ch_sel == 4'(g) && sub_sel == IOT_RL1_OFF),
            .wdata    (reg_wdata),
            .ct_o     (ct_rd[g]),
            .rl0_o    (rl0_rd[g]),
            .rl1_o    (rl1_rd[g]),
            .ff_o     (timer_out[g]),
            .irq_o    (irq_req[g]),
            .dma_o    (dma_all[g]),
            .uf_stop  (uf_stop[g])
        );
    end

    assign dma_req = dma_all[IOT_DMA_CH];

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= IOT_CNT_RST;
        end else if (reg_rd) begin
            if (reg_addr == IOT_EN_OFF) begin
                rdata_r <= {6'h00, channel_count_enable_r};
            end else if (reg_addr == IOT_PRO_OFF) begin
                rdata_r <= {6'h00, enable_write_protect_r};
            end else if (ch_ok && sub_sel == IOT_CT_OFF) begin
                rdata_r <= ct_rd[ch_sel];
            end else if (ch_ok && sub_sel == IOT_RL0_OFF) begin
                rdata_r <= rl0_rd[ch_sel];
            end else if (ch_ok && sub_sel == IOT_RL1_OFF) begin
                rdata_r <= rl1_rd[ch_sel];
            end else if (ch_ok && sub_sel == IOT_CTL_OFF) begin
                rdata_r <= {11'h000, ctl_r[ch_sel]};
            end else begin
                rdata_r <= IOT_CNT_RST;
            end
        end else begin
            rdata_r <= IOT_CNT_RST;
        end
    end

    assign reg_rdata = rdata_r;

    protect_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (en_wr && ext_en_g == 10'h000) |=>
        ((channel_count_enable_r & ~$past(channel_count_enable_r) &
          $past(enable_write_protect_r)) == 10'h000))
        else $error("protected enable bit was set by a write");
    sw_write_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        en_wr |=> (((channel_count_enable_r ^ $past(en_wbits)) &
                    ~$past(enable_write_protect_r)) == 10'h000))
        else $error("permitted enable write did not take effect");
    stop_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uf_stop != 10'h000 && !en_wr) |=>
        ((channel_count_enable_r & $past(uf_stop)) == 10'h000))
        else $error("underflow stop left the enable bit set");
    en_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == IOT_EN_OFF) |=>
        (reg_rdata == {6'h00, $past(channel_count_enable_r)}))
        else $error("enable readback wrong");
    dma_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n) dma_req);
endmodule

`default_nettype wire

// file: test/iot_timer_tb.sv
// self-checking bench for the ten-channel io_timer block
`timescale 1ns/10ps
`default_nettype none
module iot_timer_tb;
    import iot_pkg::*;
    logic        clk_sys, rst_n, reg_wr, reg_rd, dma_req;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v, w;
    logic [9:0]  count_tick, ext_enable, capture, level_in, timer_out, irq_req;
    logic [15:0] exp_q[$];
    logic [7:0]  adr_q[$];
    logic        rd_q, prev8;
    int          n_fail, total_checks, tog8, dma8, irq8;
    iot_timer i_iot_timer (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .count_tick(count_tick), .ext_enable(ext_enable), .capture(capture),
        .level_in(level_in), .timer_out(timer_out), .irq_req(irq_req), .dma_req(dma_req));
    // clock at 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one write cycle, with optional same-cycle capture or external enable events
    task automatic wr_ev(input logic [7:0] a, input logic [15:0] d, input logic [9:0] cp,
                         input logic [9:0] ex);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; capture <= cp; ext_enable <= ex;
        @(posedge clk_sys);
        reg_wr <= 1'b0; capture <= '0; ext_enable <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wr_ev(a, d, '0, '0);
    endtask
    // read: the expected value is queued, the monitor compares a cycle later
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e); adr_q.push_back(a);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // monitor: read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rd_q <= reg_rd;
        if (rd_q) chk($sformatf("rdata@%h", adr_q.pop_front()), reg_rdata, exp_q.pop_front());
        prev8 <= timer_out[8];
        if (rst_n && timer_out[8] !== prev8) tog8++;
        if (dma_req === 1'b1) dma8++;
        if (irq_req[8] === 1'b1) irq8++;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        test_done();
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {count_tick, ext_enable, capture, level_in} = '0;
        {n_fail, total_checks, tog8, dma8, irq8, rst_n} = '0;
        void'($urandom(32'h92fd8ee2));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(IOT_EN_OFF, 16'h0000); rd(IOT_PRO_OFF, 16'h0000); rd(8'h08, 16'h0000);
        wr(8'hf0, 16'hffff); rd(8'hf0, 16'h0000);
        wr(IOT_PRO_OFF, 16'h0001); wr(IOT_EN_OFF, 16'h0001);
        rd(IOT_EN_OFF, 16'h0000);
        wr(IOT_PRO_OFF, 16'h0000);
        $display("test reset and protect done");
        // single shot on channel 0, counting every cycle
        count_tick <= '1;
        wr(8'h06, 16'h0003); wr(IOT_EN_OFF, 16'h0001);
        rd(IOT_EN_OFF, 16'h0001);
        #1 chk("timer_out0 start", {15'h0, timer_out[0]}, 16'h0001);
        repeat (10) @(posedge clk_sys);
        rd(IOT_EN_OFF, 16'h0000);
        #1 chk("timer_out0 end", {15'h0, timer_out[0]}, 16'h0000);
        $display("test single shot done");
        // pwm on the dma capable channel
        v = 16'($urandom_range(2, 9));
        wr(8'h84, 16'h0001); wr(8'h86, v); wr(8'h88, {13'h0, IOT_M_PWM});
        wr(IOT_EN_OFF, 16'h0100);
        repeat (40) @(posedge clk_sys);
        wr(8'h84, 16'h0005);
        rd(8'h84, 16'h0005); rd(8'h86, v);
        wr(8'h86, 16'h0002); rd(8'h86, 16'h0002);
        wr(IOT_EN_OFF, 16'h0000);
        repeat (3) @(posedge clk_sys);
        w = timer_out[8];
        repeat (20) @(posedge clk_sys);
        chk("timer_out8 held", {15'h0, timer_out[8]}, w);
        chk("dma count", 16'(dma8), 16'(tog8 - 1));
        chk("irq count", 16'(irq8), 16'(dma8 / 2));
        $display("test pwm done");
        // measure modes with the count clock held, so values are exact
        count_tick <= '0;
        v = 16'($urandom);
        wr(8'h28, {13'h0, IOT_M_MFREE}); wr(8'h38, {13'h0, IOT_M_MCLR});
        wr(8'h20, v); wr(8'h30, 16'h1234); wr(IOT_EN_OFF, 16'h000c);
        wr_ev(8'hf0, 16'h0000, 10'h00c, '0);
        rd(8'h26, v); rd(8'h20, v);
        rd(8'h36, 16'h1234); rd(8'h30, IOT_ALL_ONES);
        w = 16'($urandom);
        wr_ev(8'h20, w, 10'h004, '0);
        rd(8'h26, w); rd(8'h20, w);
        wr(IOT_EN_OFF, 16'h0000);
        $display("test measure done");
        // external enable on channel 5 against a software stop
        wr(8'h56, 16'h0fff); wr(8'h58, 16'h0008);
        wr_ev(IOT_EN_OFF, 16'h0000, '0, 10'h020);
        rd(IOT_EN_OFF, 16'h0000);
        wr_ev(8'hf0, 16'h0000, '0, 10'h020);
        rd(IOT_EN_OFF, 16'h0020);
        wr(IOT_EN_OFF, 16'h0000);
        v = 16'($urandom);
        wr(8'h44, v); rd(8'h44, v);
        $display("test enable priority done");
        // measure wrap with the count clock running every cycle
        count_tick <= '1;
        wr(8'h20, 16'h0001); wr(IOT_EN_OFF, 16'h0004);
        rd(8'h20, 16'h0000); rd(8'h20, 16'hfffe);
        rd(IOT_EN_OFF, 16'h0004);
        $display("test measure wrap done");
        // noise filter on channel 1: valid level high, reload zero of 3
        wr(8'h16, 16'h0003); wr(8'h18, 16'h0016); wr(IOT_EN_OFF, 16'h0002);
        level_in[1] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        level_in[1] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(IOT_EN_OFF, 16'h0002); rd(8'h10, 16'h0002);
        level_in[1] <= 1'b1;
        rd(IOT_EN_OFF, 16'h0002); rd(IOT_EN_OFF, 16'h0002);
        rd(IOT_EN_OFF, 16'h0000); rd(8'h10, IOT_ALL_ONES);
        $display("test noise filter done");
        repeat (4) @(posedge clk_sys);
        test_done();
    end
endmodule
`default_nettype wire
